// ### hdl/ccd_pkg.sv
// Constants and types shared by the cascaded channel divider.
`default_nettype none

package ccd_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam int CCD_ADDR_W = 12;
  localparam logic [11:0] CCD_IDX_ST1_CNT  = 12'h199;
  localparam logic [11:0] CCD_IDX_PHASE    = 12'h19A;
  localparam logic [11:0] CCD_IDX_ST2_CNT  = 12'h19B;
  localparam logic [11:0] CCD_IDX_CTL      = 12'h19C;
  localparam logic [11:0] CCD_IDX_DCC      = 12'h19D;
  localparam logic [11:0] CCD_IDX_NEXT_CNT = 12'h19E;
  localparam logic [11:0] CCD_IDX_STATUS   = 12'h1B0;
  localparam logic [11:0] CCD_ADR_ST1_CNT  = 12'(CCD_IDX_ST1_CNT * 4);
  localparam logic [11:0] CCD_ADR_PHASE    = 12'(CCD_IDX_PHASE * 4);
  localparam logic [11:0] CCD_ADR_ST2_CNT  = 12'(CCD_IDX_ST2_CNT * 4);
  localparam logic [11:0] CCD_ADR_CTL      = 12'(CCD_IDX_CTL * 4);
  localparam logic [11:0] CCD_ADR_DCC      = 12'(CCD_IDX_DCC * 4);
  localparam logic [11:0] CCD_ADR_NEXT_CNT = 12'(CCD_IDX_NEXT_CNT * 4);
  localparam logic [11:0] CCD_ADR_STATUS   = 12'(CCD_IDX_STATUS * 4);

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CCD_LOW_MSB  = 7;
  localparam int CCD_LOW_LSB  = 4;
  localparam int CCD_HIGH_MSB = 3;
  localparam int CCD_HIGH_LSB = 0;
  localparam int CCD_PH2_MSB  = 7;
  localparam int CCD_PH2_LSB  = 4;
  localparam int CCD_PH1_MSB  = 3;
  localparam int CCD_PH1_LSB  = 0;
  localparam int CCD_BYP2     = 5;
  localparam int CCD_BYP1     = 4;
  localparam int CCD_NOSYNC   = 3;
  localparam int CCD_FORCE    = 2;
  localparam int CCD_START2   = 1;
  localparam int CCD_START1   = 0;
  localparam int CCD_DCC_OFF  = 0;

  // ---------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [7:0] CCD_RST_ST1_CNT  = 8'h00;
  localparam logic [7:0] CCD_RST_PHASE    = 8'h00;
  localparam logic [7:0] CCD_RST_ST2_CNT  = 8'h00;
  localparam logic [5:0] CCD_RST_CTL      = 6'h00;
  localparam logic       CCD_RST_DCC      = 1'h0;
  localparam logic [7:0] CCD_RST_NEXT_CNT = 8'h00;
  localparam logic [1:0] CCD_RESP_OKAY    = 2'h0;
  localparam logic [1:0] CCD_RESP_SLVERR  = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] low;
    logic [3:0] high;
    logic [3:0] phase;
    logic       start;
    logic       bypass;
  } ccd_stage_cfg_s;

  typedef enum logic [2:0] {
    CCD_SEL_NONE,
    CCD_SEL_ST1,
    CCD_SEL_PHASE,
    CCD_SEL_ST2,
    CCD_SEL_CTL,
    CCD_SEL_DCC,
    CCD_SEL_NEXT,
    CCD_SEL_STATUS
  } ccd_sel_e;

endpackage : ccd_pkg

`default_nettype wire

// ### hdl/ccd_sync2.sv
// Two-flop synchroniser for pin inputs of the channel divider.
`default_nettype none

module ccd_sync2 (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] async_i,
  output logic      [1:0] sync_o
);
  import ccd_pkg::*;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } ccd_sync_s;

  ccd_sync_s s_reg;
  ccd_sync_s s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = async_i;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.sync;

endmodule : ccd_sync2

`default_nettype wire

// ### hdl/ccd_stage.sv
// One divider stage: low and high counts, phase offset, start level.
`default_nettype none

module ccd_stage (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire ccd_pkg::ccd_stage_cfg_s cfg,
  input  wire logic                    restart,
  input  wire logic                    in_lvl,
  input  wire logic                    in_tick,
  output logic                         out_lvl,
  output logic                         out_tick
);
  import ccd_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic [3:0] phase;
    logic       lvl;
    logic       out_lvl;
    logic       out_tick;
  } ccd_stage_s;

  ccd_stage_s s_reg;
  ccd_stage_s s_next;
  logic [3:0] limit;

  // ---------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------
  // A bypassed stage is held idle, which stands for its power-down.
  always_comb begin
    s_next = s_reg;
    limit  = s_reg.lvl ? cfg.high : cfg.low;
    if (restart || cfg.bypass) begin
      s_next.lvl   = cfg.start;
      s_next.cnt   = 4'h0;
      s_next.phase = cfg.phase;
    end else if (in_tick) begin
      if (s_reg.phase != 4'h0) begin
        s_next.phase = s_reg.phase - 4'h1;
      end else if (s_reg.cnt == limit) begin
        s_next.lvl = ~s_reg.lvl;
        s_next.cnt = 4'h0;
      end else begin
        s_next.cnt = s_reg.cnt + 4'h1;
      end
    end
    s_next.out_lvl  = cfg.bypass ? in_lvl : s_next.lvl;
    s_next.out_tick = cfg.bypass ? in_tick
                                 : (s_next.lvl & ~s_reg.lvl);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign out_lvl  = s_reg.out_lvl;
  assign out_tick = s_reg.out_tick;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_count_edge;
    in_tick && !restart && !cfg.bypass && s_reg.phase == 4'h0;
  endsequence

  property p_toggle;
    seq_count_edge ##0 (s_reg.cnt == limit) |=>
      s_reg.lvl != $past(s_reg.lvl) && s_reg.cnt == 4'h0;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("Stage did not toggle at its count limit.");

  property p_hold;
    seq_count_edge ##0 (s_reg.cnt != limit) |=>
      s_reg.lvl == $past(s_reg.lvl) &&
      s_reg.cnt == $past(s_reg.cnt) + 4'h1;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Stage toggled before its count limit.");

  property p_restart;
    restart && !cfg.bypass |=>
      s_reg.lvl == $past(cfg.start) && s_reg.phase == $past(cfg.phase);
  endproperty
  a_restart: assert property (p_restart)
    else $error("Restart did not load start level and phase.");

  property p_phase_wait;
    s_reg.phase != 4'h0 && !restart && !cfg.bypass |=>
      s_reg.lvl == $past(s_reg.lvl);
  endproperty
  a_phase_wait: assert property (p_phase_wait)
    else $error("Stage level moved during its phase offset.");

  property p_bypass;
    cfg.bypass |=> out_lvl == $past(in_lvl) && out_tick == $past(in_tick);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Bypassed stage did not pass its input.");

endmodule : ccd_stage

`default_nettype wire

// ### hdl/ccd_top.sv
// Cascaded channel divider with its AXI4-Lite register slave.
//
// Our own choice: the AXI4-Lite interface to the registers.
`default_nettype none

module ccd_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        div_clk_in,
  input  wire logic        sync_in,
  output logic             div_out,
  output logic             duty_correction_en,
  output logic [7:0]       next_div_counts
);
  import ccd_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_en;
    logic [7:0]  st1_cnt;
    logic [7:0]  phase;
    logic [7:0]  st2_cnt;
    logic [5:0]  ctl;
    logic        duty_correction_disable;
    logic [7:0]  next_cnt;
    logic        clk_prev;
    logic        sync_prev;
    logic        boot;
    logic        div_out;
    logic        dcc_en;
  } ccd_top_s;

  localparam ccd_top_s CCD_TOP_RST = '{
    st1_cnt:                 CCD_RST_ST1_CNT,
    phase:                   CCD_RST_PHASE,
    st2_cnt:                 CCD_RST_ST2_CNT,
    ctl:                     CCD_RST_CTL,
    duty_correction_disable: CCD_RST_DCC,
    next_cnt:                CCD_RST_NEXT_CNT,
    boot:                    1'b1,
    default:                 '0
  };

  ccd_top_s       s_reg;
  ccd_top_s       s_next;
  logic [1:0]     pins_sync;
  logic           clk_sync;
  logic           sync_lvl;
  logic           clk_tick;
  logic           sync_rise;
  logic           restart;
  ccd_stage_cfg_s cfg1;
  ccd_stage_cfg_s cfg2;
  logic           st1_lvl;
  logic           st1_tick;
  logic           st2_lvl;
  logic           st2_tick;
  ccd_sel_e       wsel;
  ccd_sel_e       rsel;

  // ---------------------------------------------------------------
  // Address decoding
  // ---------------------------------------------------------------
  function automatic ccd_sel_e reg_sel(input logic [11:0] a);
    ccd_sel_e sel;
    sel = CCD_SEL_NONE;
    if (a == CCD_ADR_ST1_CNT) begin
      sel = CCD_SEL_ST1;
    end else if (a == CCD_ADR_PHASE) begin
      sel = CCD_SEL_PHASE;
    end else if (a == CCD_ADR_ST2_CNT) begin
      sel = CCD_SEL_ST2;
    end else if (a == CCD_ADR_CTL) begin
      sel = CCD_SEL_CTL;
    end else if (a == CCD_ADR_DCC) begin
      sel = CCD_SEL_DCC;
    end else if (a == CCD_ADR_NEXT_CNT) begin
      sel = CCD_SEL_NEXT;
    end else if (a == CCD_ADR_STATUS) begin
      sel = CCD_SEL_STATUS;
    end
    return sel;
  endfunction : reg_sel

  // ---------------------------------------------------------------
  // Pin synchronisers and stages
  // ---------------------------------------------------------------
  ccd_sync2 u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .async_i ({sync_in, div_clk_in}),
    .sync_o  (pins_sync)
  );

  assign clk_sync  = pins_sync[0];
  assign sync_lvl  = pins_sync[1];
  assign clk_tick  = clk_sync & ~s_reg.clk_prev;
  assign sync_rise = sync_lvl & ~s_reg.sync_prev;
  // Power-up counts as a sync event whatever the no-sync bit says.
  assign restart   = s_reg.boot |
                     (sync_rise & ~s_reg.ctl[CCD_NOSYNC]);

  always_comb begin
    cfg1.low    = s_reg.st1_cnt[CCD_LOW_MSB:CCD_LOW_LSB];
    cfg1.high   = s_reg.st1_cnt[CCD_HIGH_MSB:CCD_HIGH_LSB];
    cfg1.phase  = s_reg.phase[CCD_PH1_MSB:CCD_PH1_LSB];
    cfg1.start  = s_reg.ctl[CCD_START1];
    cfg1.bypass = s_reg.ctl[CCD_BYP1];
    cfg2.low    = s_reg.st2_cnt[CCD_LOW_MSB:CCD_LOW_LSB];
    cfg2.high   = s_reg.st2_cnt[CCD_HIGH_MSB:CCD_HIGH_LSB];
    cfg2.phase  = s_reg.phase[CCD_PH2_MSB:CCD_PH2_LSB];
    cfg2.start  = s_reg.ctl[CCD_START2];
    cfg2.bypass = s_reg.ctl[CCD_BYP2];
  end

  ccd_stage u_stage1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cfg      (cfg1),
    .restart  (restart),
    .in_lvl   (clk_sync),
    .in_tick  (clk_tick),
    .out_lvl  (st1_lvl),
    .out_tick (st1_tick)
  );

  // The second stage counts whole periods of the first stage output.
  ccd_stage u_stage2 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cfg      (cfg2),
    .restart  (restart),
    .in_lvl   (st1_lvl),
    .in_tick  (st1_tick),
    .out_lvl  (st2_lvl),
    .out_tick (st2_tick)
  );

  // ---------------------------------------------------------------
  // Register slave and output logic
  // ---------------------------------------------------------------
  always_comb begin
    s_next           = s_reg;
    wsel             = reg_sel(s_reg.aw_addr);
    rsel             = reg_sel(s_axi_araddr);
    s_next.boot      = 1'b0;
    s_next.clk_prev  = clk_sync;
    s_next.sync_prev = sync_lvl;

    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_en   = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = CCD_RESP_OKAY;
      if (s_reg.w_en) begin
        case (wsel)
          CCD_SEL_ST1:   s_next.st1_cnt  = s_reg.w_data;
          CCD_SEL_PHASE: s_next.phase    = s_reg.w_data;
          CCD_SEL_ST2:   s_next.st2_cnt  = s_reg.w_data;
          CCD_SEL_CTL:   s_next.ctl      = s_reg.w_data[5:0];
          CCD_SEL_DCC:   s_next.duty_correction_disable =
                           s_reg.w_data[CCD_DCC_OFF];
          CCD_SEL_NEXT:  s_next.next_cnt = s_reg.w_data;
          default: begin
          end
        endcase
      end
      // Unmapped addresses answer with an error; status writes are ignored.
      if (wsel == CCD_SEL_NONE) begin
        s_next.bresp = CCD_RESP_SLVERR;
      end
    end

    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = CCD_RESP_OKAY;
      s_next.rdata  = 32'h0;
      case (rsel)
        CCD_SEL_ST1:    s_next.rdata[7:0] = s_reg.st1_cnt;
        CCD_SEL_PHASE:  s_next.rdata[7:0] = s_reg.phase;
        CCD_SEL_ST2:    s_next.rdata[7:0] = s_reg.st2_cnt;
        CCD_SEL_CTL:    s_next.rdata[5:0] = s_reg.ctl;
        CCD_SEL_DCC:    s_next.rdata[0] = s_reg.duty_correction_disable;
        CCD_SEL_NEXT:   s_next.rdata[7:0] = s_reg.next_cnt;
        CCD_SEL_STATUS: s_next.rdata[3:0] =
                          {sync_lvl, st2_lvl, st1_lvl, s_reg.div_out};
        default:        s_next.rresp = CCD_RESP_SLVERR;
      endcase
    end

    s_next.awready = ~s_next.aw_held & ~s_next.bvalid;
    s_next.wready  = ~s_next.w_held & ~s_next.bvalid;
    s_next.arready = ~s_next.rvalid;

    if (s_reg.ctl[CCD_NOSYNC]) begin
      s_next.div_out = s_reg.ctl[CCD_FORCE];
    end else begin
      s_next.div_out = st2_lvl;
    end
    s_next.dcc_en = ~s_reg.duty_correction_disable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= CCD_TOP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready      = s_reg.awready;
  assign s_axi_wready       = s_reg.wready;
  assign s_axi_bresp        = s_reg.bresp;
  assign s_axi_bvalid       = s_reg.bvalid;
  assign s_axi_arready      = s_reg.arready;
  assign s_axi_rdata        = s_reg.rdata;
  assign s_axi_rresp        = s_reg.rresp;
  assign s_axi_rvalid       = s_reg.rvalid;
  assign div_out            = s_reg.div_out;
  assign duty_correction_en = s_reg.dcc_en;
  assign next_div_counts    = s_reg.next_cnt;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_wr_commit;
    s_reg.aw_held && s_reg.w_held && !s_reg.bvalid && s_reg.w_en;
  endsequence

  property p_sync_obeyed;
    sync_rise && !s_reg.ctl[CCD_NOSYNC] && !s_reg.ctl[CCD_BYP1] |=>
      st1_lvl == $past(s_reg.ctl[CCD_START1]);
  endproperty
  a_sync_obeyed: assert property (p_sync_obeyed)
    else $error("Sync edge was not obeyed.");

  property p_sync_ignored;
    sync_rise && s_reg.ctl[CCD_NOSYNC] && !clk_tick &&
      !s_reg.ctl[CCD_BYP1] && $stable(s_reg.ctl) |=> $stable(st1_lvl);
  endproperty
  a_sync_ignored: assert property (p_sync_ignored)
    else $error("Sync edge was not ignored under no-sync.");

  property p_force;
    s_reg.ctl[CCD_NOSYNC] ##1 s_reg.ctl[CCD_NOSYNC] |->
      div_out == $past(s_reg.ctl[CCD_FORCE]);
  endproperty
  a_force: assert property (p_force)
    else $error("Output not held at the force level.");

  property p_dcc;
    s_reg.duty_correction_disable ##1 s_reg.duty_correction_disable
      |-> !duty_correction_en;
  endproperty
  a_dcc: assert property (p_dcc)
    else $error("Duty correction still enabled when disabled.");

  property p_st2_write;
    seq_wr_commit ##0 (wsel == CCD_SEL_ST2) |=>
      s_reg.st2_cnt == $past(s_reg.w_data) && s_axi_bvalid;
  endproperty
  a_st2_write: assert property (p_st2_write)
    else $error("Second stage counts not written.");

  property p_next_write;
    seq_wr_commit ##0 (wsel == CCD_SEL_NEXT) |=>
      next_div_counts == $past(s_reg.w_data);
  endproperty
  a_next_write: assert property (p_next_write)
    else $error("Next divider counts not written.");

endmodule : ccd_top

`default_nettype wire

// ### tb/test_cascaded_channel_divider.sv
// Self-checking testbench for the cascaded channel divider.
`default_nettype none

module test_cascaded_channel_divider;
  timeunit 1ns;
  timeprecision 1ns;
  import ccd_pkg::*;

  logic        aclk, aresetn, div_clk_in, sync_in;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dcnt;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, div_out, duty_correction_en;
  logic [7:0]  next_div_counts;
  int          n_fail, n_checks;
  logic [31:0] seed;
  logic [11:0] adr [6];

  ccd_top uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .div_clk_in(div_clk_in), .sync_in(sync_in), .div_out(div_out),
    .duty_correction_en(duty_correction_en),
    .next_div_counts(next_div_counts)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // The divider input runs at a quarter of aclk: one rising edge per 4.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dcnt       <= 2'h0;
      div_clk_in <= 1'b0;
    end else begin
      dcnt       <= dcnt + 2'h1;
      div_clk_in <= dcnt[1];
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [31:0] exp_rd(input int i, input logic [7:0] v);
    if (i == 3) return {26'h0, v[5:0]};
    if (i == 4) return {31'h0, v[0]};
    return {24'h0, v};
  endfunction : exp_rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic axw(input logic [11:0] a, input logic [7:0] d,
                     output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (i == 200) n_fail++;
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (i == 200) n_fail++;
  endtask : axr

  task automatic wait_lvl(input logic v);
    int j;
    for (j = 0; j < 2000 && div_out !== v; j++) @(posedge aclk);
  endtask : wait_lvl

  task automatic meas(output int hi, output int lo);
    wait_lvl(0); wait_lvl(1); wait_lvl(0); wait_lvl(1);
    for (hi = 0; hi < 2000 && div_out === 1'b1; hi++) @(posedge aclk);
    for (lo = 0; lo < 2000 && div_out === 1'b0; lo++) @(posedge aclk);
  endtask : meas

  // Time from the sync pin edge until the output leaves its start level.
  task automatic sync_run(input logic [5:0] c, input logic [7:0] ph,
                          input logic st, output int t);
    logic [1:0] r;
    axw(CCD_ADR_PHASE, ph, r);
    axw(CCD_ADR_CTL, {2'h0, c}, r);
    @(posedge aclk iff dcnt == 2'h0);
    sync_in <= 1'b1;
    for (t = 1; t < 400; t++) begin
      @(posedge aclk);
      if (t == 4) sync_in <= 1'b0;
      if (t == 10) chk({31'h0, div_out}, {31'h0, st});
      if (t > 10 && div_out !== st) break;
    end
  endtask : sync_run

  initial begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    stop_test();
  end

  initial begin
    int i, k, hi, lo, t0, t1;
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  lc, hc;
    logic [5:0]  c;
    adr = '{CCD_ADR_ST1_CNT, CCD_ADR_PHASE, CCD_ADR_ST2_CNT, CCD_ADR_CTL,
            CCD_ADR_DCC, CCD_ADR_NEXT_CNT};
    {aresetn, sync_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0; s_axi_wstrb = 4'hF;
    n_fail = 0; n_checks = 0; seed = 32'h64D0AFF4;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (i = 0; i < 6; i++) begin
      axr(adr[i], d, r);
      chk(d, 32'h0);
    end
    chk({31'h0, duty_correction_en}, 32'h1);
    axr(12'h004, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, CCD_RESP_SLVERR});
    axw(12'h004, 8'hFF, r);
    chk({30'h0, r}, {30'h0, CCD_RESP_SLVERR});
    axw(CCD_ADR_STATUS, 8'hFF, r);
    chk({30'h0, r}, {30'h0, CCD_RESP_OKAY});
    s_axi_wstrb <= 4'hE;
    axw(CCD_ADR_NEXT_CNT, 8'hAA, r);
    s_axi_wstrb <= 4'hF;
    chk({22'h0, r, next_div_counts}, {22'h0, CCD_RESP_OKAY, 8'h00});
    for (k = 0; k < 14; k++) begin
      seed = lfsr(seed);
      i = (k < 6) ? k : int'(seed[10:8]) % 6;
      axw(adr[i], seed[7:0], r);
      axr(adr[i], d, r);
      chk(d, exp_rd(i, seed[7:0]));
      if (i == 5) chk({24'h0, next_div_counts}, {24'h0, seed[7:0]});
      if (i == 4) chk({31'h0, duty_correction_en},
                      {31'h0, ~seed[0]});
    end
    axw(CCD_ADR_PHASE, 8'h00, r);
    for (k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      lc = (k == 1) ? 4'hF : (k == 0) ? 4'h0 : {1'b0, seed[2:0]};
      hc = (k == 2) ? 4'hF : (k == 0) ? 4'h0 : {1'b0, seed[6:4]};
      c = (k % 3 == 0) ? 6'h20 : (k % 3 == 1) ? 6'h10 : 6'h00;
      axw(CCD_ADR_CTL, {2'h0, c}, r);
      axw(CCD_ADR_ST1_CNT, (k % 3 == 2) ? 8'h00 : {lc, hc}, r);
      axw(CCD_ADR_ST2_CNT, {lc, hc}, r);
      meas(hi, lo);
      t0 = (k % 3 == 2) ? 8 : 4;
      chk(hi, (hc + 1) * t0);
      chk(lo, (lc + 1) * t0);
    end
    for (k = 0; k < 2; k++) begin
      axw(CCD_ADR_CTL, {4'h0, 1'b1, k[0], 2'h0}, r);
      repeat (6) @(posedge aclk);
      for (i = 0; i < 20; i++) begin
        // Sync pulses that no-sync must ignore, at two tick phases.
        if (i == 2 || i == 11) sync_in <= 1'b1;
        if (i == 5 || i == 14) sync_in <= 1'b0;
        chk({31'h0, div_out}, {31'h0, k[0]});
        @(posedge aclk);
      end
      axr(CCD_ADR_STATUS, d, r);
      chk({d[31:4], r, d[3], d[0]},
          {28'h0, CCD_RESP_OKAY, 1'b0, k[0]});
    end
    axw(CCD_ADR_ST1_CNT, 8'h33, r);
    axw(CCD_ADR_ST2_CNT, 8'h33, r);
    for (k = 0; k < 4; k++) begin
      c = k[1] ? {4'h4, k[0], 1'b0} : {5'h10, k[0]};
      sync_run(c, 8'h00, k[0], t0);
      sync_run(c, k[1] ? 8'h30 : 8'h03, k[0], t1);
      chk(t1 - t0, 12);
    end
    stop_test();
  end

endmodule : test_cascaded_channel_divider

`default_nettype wire
